// ===== verilog/dcm_pkg.sv
// Purpose: constants and types for the duty cycle / timeout measurement channel
// Assumes: 100 MHz measurement clock, results are IEEE single precision words
// Notes: crank angle is counted in whole degrees over one 720 degree cycle
//
// Contract
// - timeout when no new value since last check
// - cycle timeout value is time since edge
// - frequency timeout value is inverse elapsed time
// - predefined procedures issue configured default value
// - pulse/pulse duty is L/H or H/L
// - pulse/period duty is L or H over L+H
// - every ratio selectable on rising or falling edge
// - duty follows same async and windowed behaviour
// - async every edge, windowed only inside window
// - full 720 degree window equals asynchronous mode
// - pulse/pulse timeout gives zero on listed level
// - pulse/pulse timeout gives max float otherwise
// - pulse/period timeout gives zero on listed level
// - pulse/period timeout gives one otherwise
package dcm_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int NS_PER_S = 1000000000;
  localparam int TICKS_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int CLK_HZ = NS_PER_S / CLK_PERIOD_NS;

  localparam int ANGLE_RANGE = 720;
  localparam int FLOAT_BIAS = 127;
  localparam int MANT_BITS = 24;

  localparam logic [31:0] FLOAT_ZERO = 32'h0000_0000;
  localparam logic [31:0] FLOAT_ONE = 32'h3f80_0000;
  localparam logic [31:0] MAX_SINGLE_FLOAT = 32'h7f7f_ffff;

  localparam logic EDGE_RISING = 1'b0;

  typedef enum logic [2:0] {
    KIND_CYCLE = 3'b000,
    KIND_FREQ = 3'b001,
    KIND_DUTY_LH = 3'b010,
    KIND_DUTY_HL = 3'b011,
    KIND_DUTY_L_LH = 3'b100,
    KIND_DUTY_H_LH = 3'b101
  } dcm_kind_e;

  typedef enum logic [1:0] {
    TMO_INTERVAL = 2'b00,
    TMO_ANGLE = 2'b01,
    TMO_BOTH = 2'b10
  } dcm_tmo_src_e;

  typedef enum logic {
    DIV_IDLE = 1'b0,
    DIV_RUN = 1'b1
  } dcm_div_state_e;

endpackage

// ===== verilog/dcm_div_if.sv
// Purpose: request and answer wires between channel and float divider
// Assumes: one request in flight at a time
// Notes: busy is high while a quotient is being built
`timescale 1ns/100ps
interface dcm_div_if #(parameter int OW = 33);
  logic start;
  logic [OW-1:0] num;
  logic [OW-1:0] den;
  logic busy;
  logic done;
  logic [31:0] quot;

  modport master(output start, output num, output den, input busy, input done, input quot);
  modport slave(input start, input num, input den, output busy, output done, output quot);
endinterface

// ===== verilog/dcm_fdiv.sv
// Purpose: unsigned integer quotient num/den as an IEEE single precision word
// Assumes: start only while not busy
// Notes: mantissa is truncated, not rounded; zero and divide-by-zero answer in one cycle
`timescale 1ns/100ps
module dcm_fdiv
  import dcm_pkg::*;
#(
  parameter int OW = 33
) (
  input wire logic clock_i,
  input wire logic rst_i,
  dcm_div_if.slave div
);

  typedef struct packed {
    dcm_div_state_e state;
    logic [4:0] cnt;
    logic [OW:0] rem;
    logic [OW-1:0] dd;
    logic [MANT_BITS-1:0] q;
    logic [7:0] expo;
    logic [31:0] quot;
    logic done;
  } dcm_div_s;

  dcm_div_s st_q;
  dcm_div_s st_d;

  function automatic logic [5:0] lzc(input logic [OW-1:0] v);
    logic [5:0] n;
    logic found;
    n = 6'(OW);
    found = 1'b0;
    for (int i = OW - 1; i >= 0; i--) begin
      if (!found && v[i]) begin
        n = 6'(OW - 1 - i);
        found = 1'b1;
      end
    end
    return n;
  endfunction

  logic [5:0] lzn;
  logic [5:0] lzd;
  logic [OW-1:0] nn;
  logic [OW-1:0] dn;
  logic [9:0] expo;
  logic bit_v;
  logic [OW:0] rem_sub;
  logic [MANT_BITS-1:0] q_new;

  assign div.busy = (st_q.state == DIV_RUN);
  assign div.done = st_q.done;
  assign div.quot = st_q.quot;

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    lzn = lzc(div.num);
    lzd = lzc(div.den);
    nn = div.num << lzn;
    dn = div.den << lzd;
    // both operands normalised to a leading one, so the quotient sits in [0.5, 2)
    expo = 10'(FLOAT_BIAS) + 10'(lzd) - 10'(lzn);
    bit_v = (st_q.rem >= {1'b0, st_q.dd});
    rem_sub = bit_v ? (st_q.rem - {1'b0, st_q.dd}) : st_q.rem;
    q_new = {st_q.q[MANT_BITS-2:0], bit_v};
    unique case (st_q.state)
      DIV_IDLE: begin
        if (div.start) begin
          if (div.num == '0) begin
            st_d.quot = FLOAT_ZERO;
            st_d.done = 1'b1;
          end else if (div.den == '0) begin
            st_d.quot = MAX_SINGLE_FLOAT;
            st_d.done = 1'b1;
          end else begin
            st_d.state = DIV_RUN;
            st_d.cnt = 5'h00;
            st_d.dd = dn;
            st_d.q = '0;
            if (nn < dn) begin
              st_d.rem = {nn, 1'b0};
              st_d.expo = expo[7:0] - 8'h01;
            end else begin
              st_d.rem = {1'b0, nn};
              st_d.expo = expo[7:0];
            end
          end
        end
      end
      DIV_RUN: begin
        st_d.rem = {rem_sub[OW-1:0], 1'b0};
        st_d.q = q_new;
        st_d.cnt = st_q.cnt + 5'h01;
        if (st_q.cnt == 5'(MANT_BITS - 1)) begin
          st_d.state = DIV_IDLE;
          st_d.done = 1'b1;
          st_d.quot = {1'b0, st_q.expo, q_new[MANT_BITS-2:0]};
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_div_latency: assert property (
    (div.start && !div.busy && div.num != '0 && div.den != '0) |-> ##25 div.done)
    else $error("divider answer not 25 cycles after start");

endmodule // dcm_fdiv

// ===== verilog/dcm_channel.sv
// Purpose: one input capture channel: cycle time, frequency, duty cycle, timeout values
// Assumes: sig_i and angle_i synchronous to clock_i; configuration held steady while running
// Notes: results are single precision words; one division in flight, newest request wins
`timescale 1ns/100ps
module dcm_channel
  import dcm_pkg::*;
#(
  parameter int CW = 32,
  parameter int AW = 10
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sig_i,
  input wire logic edge_falling_i,
  input wire logic [2:0] kind_i,
  input wire logic angle_synchronous_mode_i,
  input wire logic [AW-1:0] angle_i,
  input wire logic [AW-1:0] win_lo_i,
  input wire logic [AW-1:0] win_hi_i,
  input wire logic [1:0] tmo_src_i,
  input wire logic tmo_predef_i,
  input wire logic [CW-1:0] tmo_interval_i,
  input wire logic [AW-1:0] tmo_angle_i,
  input wire logic [31:0] default_value_i,
  output logic [31:0] result_o,
  output logic valid_o,
  output logic timeout_o
);

  localparam int OW = CW + 1;

  typedef struct packed {
    logic sig;
    logic [CW-1:0] low;
    logic [CW-1:0] high;
    logic [CW-1:0] phase;
    logic [CW-1:0] elapsed;
    logic [CW-1:0] ivl;
    logic have_low;
    logic have_high;
    logic have_edge;
    logic fresh;
    logic [AW-1:0] angle_prev;
    logic pend;
    logic pend_byp;
    logic pend_tmo;
    logic [OW-1:0] pend_num;
    logic [OW-1:0] pend_den;
    logic [31:0] pend_val;
    logic run;
    logic run_tmo;
    logic [31:0] result;
    logic valid;
    logic timeout;
  } dcm_chan_s;

  dcm_chan_s st_q;
  dcm_chan_s st_d;

  dcm_div_if #(.OW(OW)) div_if ();

  dcm_fdiv #(.OW(OW)) u_div (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .div(div_if.slave)
  );

  // counters stick at full scale so a dead input never wraps into a short period
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction

  logic rise;
  logic fall;
  logic act_edge;
  logic [CW-1:0] ph1;
  logic [CW-1:0] el1;
  logic [CW-1:0] new_low;
  logic [CW-1:0] new_high;
  logic have_low_n;
  logic have_high_n;
  logic in_win;
  logic gate;
  logic ready;
  logic meas_evt;
  logic [OW-1:0] m_num;
  logic [OW-1:0] m_den;
  logic [OW-1:0] lw;
  logic [OW-1:0] hw;
  logic [CW:0] ivl1;
  logic ivl_on;
  logic ang_on;
  logic ivl_hit;
  logic ang_hit;
  logic check;
  logic tmo_fire;
  logic t_byp;
  logic [31:0] t_val;
  logic [OW-1:0] t_num;
  logic [OW-1:0] t_den;
  logic issue;

  assign issue = st_q.pend & ~st_q.run & ~div_if.busy;
  assign div_if.start = issue & ~st_q.pend_byp;
  assign div_if.num = st_q.pend_num;
  assign div_if.den = st_q.pend_den;

  assign result_o = st_q.result;
  assign valid_o = st_q.valid;
  assign timeout_o = st_q.timeout;

  always_comb begin
    st_d = st_q;
    st_d.valid = 1'b0;
    rise = sig_i & ~st_q.sig;
    fall = ~sig_i & st_q.sig;
    act_edge = (edge_falling_i == EDGE_RISING) ? rise : fall;
    ph1 = sat_inc(st_q.phase);
    el1 = sat_inc(st_q.elapsed);
    // a phase that ends right now is the newest completed one
    new_low = rise ? ph1 : st_q.low;
    new_high = fall ? ph1 : st_q.high;
    have_low_n = st_q.have_low | rise;
    have_high_n = st_q.have_high | fall;
    lw = {1'b0, new_low};
    hw = {1'b0, new_high};

    // a window with lo above hi wraps through zero degrees
    if (win_lo_i <= win_hi_i) begin
      in_win = (angle_i >= win_lo_i) && (angle_i <= win_hi_i);
    end else begin
      in_win = (angle_i >= win_lo_i) || (angle_i <= win_hi_i);
    end
    gate = ~angle_synchronous_mode_i | in_win;

    m_num = '0;
    m_den = '0;
    ready = 1'b0;
    unique case (kind_i)
      KIND_CYCLE: begin
        ready = st_q.have_edge;
        m_num = {1'b0, el1};
        m_den = OW'(TICKS_PER_US);
      end
      KIND_FREQ: begin
        ready = st_q.have_edge;
        m_num = OW'(CLK_HZ);
        m_den = {1'b0, el1};
      end
      KIND_DUTY_LH: begin
        ready = have_low_n & have_high_n;
        m_num = lw;
        m_den = hw;
      end
      KIND_DUTY_HL: begin
        ready = have_low_n & have_high_n;
        m_num = hw;
        m_den = lw;
      end
      KIND_DUTY_L_LH: begin
        ready = have_low_n & have_high_n;
        m_num = lw;
        m_den = lw + hw;
      end
      KIND_DUTY_H_LH: begin
        ready = have_low_n & have_high_n;
        m_num = hw;
        m_den = lw + hw;
      end
      default: begin
        ready = 1'b0;
      end
    endcase
    meas_evt = act_edge & gate & ready;

    ivl_on = (tmo_src_i != TMO_ANGLE);
    ang_on = (tmo_src_i != TMO_INTERVAL);
    ivl1 = {1'b0, st_q.ivl} + 1'b1;
    // an interval of zero behaves as one cycle
    ivl_hit = ivl_on && (ivl1 >= {1'b0, tmo_interval_i});
    ang_hit = ang_on && (angle_i == tmo_angle_i) && (st_q.angle_prev != tmo_angle_i);
    check = ivl_hit | ang_hit;
    // a value arriving in the very check cycle counts as fresh
    tmo_fire = check & ~st_q.fresh & ~meas_evt;

    t_byp = 1'b1;
    t_val = default_value_i;
    t_num = '0;
    t_den = '0;
    if (!tmo_predef_i) begin
      unique case (kind_i)
        KIND_CYCLE: begin
          t_byp = 1'b0;
          t_num = {1'b0, el1};
          t_den = OW'(TICKS_PER_US);
        end
        KIND_FREQ: begin
          t_byp = 1'b0;
          t_num = OW'(CLK_HZ);
          t_den = {1'b0, el1};
        end
        KIND_DUTY_LH: t_val = sig_i ? FLOAT_ZERO : MAX_SINGLE_FLOAT;
        KIND_DUTY_HL: t_val = sig_i ? MAX_SINGLE_FLOAT : FLOAT_ZERO;
        KIND_DUTY_L_LH: t_val = sig_i ? FLOAT_ZERO : FLOAT_ONE;
        KIND_DUTY_H_LH: t_val = sig_i ? FLOAT_ONE : FLOAT_ZERO;
        default: t_val = FLOAT_ZERO;
      endcase
    end

    st_d.sig = sig_i;
    st_d.angle_prev = angle_i;
    st_d.low = new_low;
    st_d.high = new_high;
    st_d.have_low = have_low_n;
    st_d.have_high = have_high_n;
    st_d.phase = (rise | fall) ? '0 : ph1;
    st_d.elapsed = act_edge ? '0 : el1;
    st_d.have_edge = st_q.have_edge | act_edge;
    st_d.ivl = (!ivl_on || ivl_hit) ? '0 : ivl1[CW-1:0];
    st_d.fresh = meas_evt | (st_q.fresh & ~check);

    // hand the pending request on before a new one can overwrite it
    if (issue) begin
      st_d.pend = 1'b0;
      if (st_q.pend_byp) begin
        st_d.result = st_q.pend_val;
        st_d.valid = 1'b1;
        st_d.timeout = st_q.pend_tmo;
      end else begin
        st_d.run = 1'b1;
        st_d.run_tmo = st_q.pend_tmo;
      end
    end
    if (st_q.run && div_if.done) begin
      st_d.run = 1'b0;
      st_d.result = div_if.quot;
      st_d.valid = 1'b1;
      st_d.timeout = st_q.run_tmo;
    end

    if (meas_evt) begin
      st_d.pend = 1'b1;
      st_d.pend_byp = 1'b0;
      st_d.pend_tmo = 1'b0;
      st_d.pend_num = m_num;
      st_d.pend_den = m_den;
    end else if (tmo_fire) begin
      st_d.pend = 1'b1;
      st_d.pend_byp = t_byp;
      st_d.pend_tmo = 1'b1;
      st_d.pend_val = t_val;
      st_d.pend_num = t_num;
      st_d.pend_den = t_den;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_timeout_fired;
    tmo_fire && !tmo_predef_i;
  endsequence

  sequence s_division_issued;
    issue && !st_q.pend_byp;
  endsequence

  a_timeout_declared: assert property (
    tmo_fire |=> st_q.pend && st_q.pend_tmo)
    else $error("missed timeout after a quiet check interval");

  a_fresh_cleared: assert property (
    (check && !meas_evt) |=> !st_q.fresh ##1 (st_q.fresh || !$past(meas_evt)))
    else $error("fresh flag not cleared by a timeout check");

  a_cycle_tmo_value: assert property (
    (s_timeout_fired and kind_i == KIND_CYCLE) |=>
      st_q.pend_num == {1'b0, $past(el1)} && st_q.pend_den == OW'(TICKS_PER_US))
    else $error("cycle timeout does not carry elapsed time");

  a_freq_tmo_value: assert property (
    (s_timeout_fired and kind_i == KIND_FREQ) |=>
      st_q.pend_den == {1'b0, $past(el1)} && st_q.pend_num == OW'(CLK_HZ))
    else $error("frequency timeout is not the inverse of elapsed time");

  a_predef_default: assert property (
    (tmo_fire && tmo_predef_i) |=> st_q.pend_byp && st_q.pend_val == $past(default_value_i))
    else $error("predefined timeout does not carry the default value");

  a_pp_tmo_value: assert property (
    (s_timeout_fired and kind_i == KIND_DUTY_LH) |=>
      st_q.pend_val == ($past(sig_i) ? FLOAT_ZERO : MAX_SINGLE_FLOAT))
    else $error("pulse ratio timeout value wrong for input level");

  a_pc_tmo_value: assert property (
    (s_timeout_fired and kind_i == KIND_DUTY_H_LH) |=>
      st_q.pend_val == ($past(sig_i) ? FLOAT_ONE : FLOAT_ZERO))
    else $error("period ratio timeout value wrong for input level");

  a_duty_period_sum: assert property (
    (meas_evt && kind_i == KIND_DUTY_L_LH) |=>
      st_q.pend_den == st_q.pend_num + {1'b0, $past(new_high)})
    else $error("period ratio denominator is not low plus high");

  a_phase_newest: assert property (
    (meas_evt && rise && kind_i == KIND_DUTY_LH) |=> st_q.pend_num == {1'b0, $past(ph1)})
    else $error("duty ratio did not use the phase ending at this edge");

  a_window_gate: assert property (
    (act_edge && angle_synchronous_mode_i && !in_win && !check) |=>
      st_q.fresh == $past(st_q.fresh))
    else $error("edge outside the angle window produced a value");

  a_result_latency: assert property (
    s_division_issued |-> ##[1:26] st_q.valid)
    else $error("division result not delivered in time");

endmodule // dcm_channel

// ===== verif/dcm_sig_model.sv
// Purpose: model of the monitored digital input with programmable high and low phases
// Assumes: phase lengths of at least one clock cycle
// Notes: when stopped it parks at a chosen level, as a real sensor line would stay put
`timescale 1ns/100ps
module dcm_sig_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic park_i,
  input wire logic [7:0] hi_len_i,
  input wire logic [7:0] lo_len_i,
  output logic sig_o
);
  logic [7:0] cnt_q;
  // changes only just after a rising edge, so the channel samples a settled level
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sig_o <= 1'b0;
      cnt_q <= 8'h00;
    end else if (!run_i) begin
      sig_o <= park_i;
      cnt_q <= 8'h00;
    end else if (cnt_q + 8'h01 >= (sig_o ? hi_len_i : lo_len_i)) begin
      sig_o <= ~sig_o;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // dcm_sig_model

// ===== verif/tb_top.sv
// Purpose: self-checking bench for the duty cycle and timeout channel
// Assumes: expected floats truncate the mantissa like the channel does
// Notes: timeout values of elapsed time are checked against a window of cycles
`timescale 1ns/100ps
module tb_top;
  import dcm_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic sig, edge_f, amode, tpre, run, park, arun;
  logic [2:0] kind;
  logic [9:0] angle, aset, wlo, whi, tang;
  logic [1:0] tsrc;
  logic [31:0] tint, dflt, res, rnd, lo_w, hi_w;
  logic [7:0] hl, ll;
  logic valid, tmo, t;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int since = 0;
  logic sig_prev = 1'b0;

  dcm_channel dut_u (.clock_i(clock_i), .rst_i(rst_i), .sig_i(sig), .edge_falling_i(edge_f),
    .kind_i(kind), .angle_synchronous_mode_i(amode), .angle_i(angle), .win_lo_i(wlo),
    .win_hi_i(whi), .tmo_src_i(tsrc), .tmo_predef_i(tpre), .tmo_interval_i(tint),
    .tmo_angle_i(tang), .default_value_i(dflt), .result_o(res), .valid_o(valid),
    .timeout_o(tmo));
  dcm_sig_model sig_u (.clock_i(clock_i), .rst_i(rst_i), .run_i(run), .park_i(park),
    .hi_len_i(hl), .lo_len_i(ll), .sig_o(sig));

  always #5 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    cyc++;
    since <= (sig && !sig_prev) ? 0 : since + 1;
    sig_prev <= sig;
    // angle has one driver: a free running crank, or parked where the stimulus puts it
    if (arun) begin
      angle <= (angle == 10'h2cf) ? 10'h000 : angle + 10'h001;
    end else begin
      angle <= aset;
    end
    if (cyc == 60000) begin
      mismatches++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // unsigned quotient as a single float, mantissa truncated
  function automatic logic [31:0] fq(input longint n, input longint d);
    int e;
    longint q;
    e = 0;
    if (n == 0) return FLOAT_ZERO;
    while (n >= (d << 1)) begin d = d << 1; e++; end
    while (n < d) begin n = n << 1; e--; end
    q = (n << 23) / d;
    return {1'b0, 8'(e + FLOAT_BIAS), q[22:0]};
  endfunction

  function automatic logic [31:0] expv(input int k, input longint h, input longint l);
    case (k)
      0: return fq(h + l, 100);
      1: return fq(100000000, h + l);
      2: return fq(l, h);
      3: return fq(h, l);
      4: return fq(l, h + l);
      default: return fq(h, h + l);
    endcase
  endfunction

  function automatic logic [31:0] tmov(input int k, input logic lv);
    case (k)
      2: return lv ? FLOAT_ZERO : MAX_SINGLE_FLOAT;
      3: return lv ? MAX_SINGLE_FLOAT : FLOAT_ZERO;
      4: return lv ? FLOAT_ZERO : FLOAT_ONE;
      default: return lv ? FLOAT_ONE : FLOAT_ZERO;
    endcase
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    total_checks++;
    if (!(got >= lo && got <= hi)) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // waits a bounded time for the next result, optionally only a timeout one
  task automatic get(input bit want_t, output logic [31:0] r, output logic tf);
    int i;
    r = 32'hxxxx_xxxx;
    tf = 1'bx;
    for (i = 0; i < 2000; i++) begin
      @(posedge clock_i);
      #1;
      if (valid === 1'b1 && (!want_t || tmo === 1'b1)) begin
        r = res;
        tf = tmo;
        break;
      end
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    int n;
    edge_f = 1'b0; amode = 1'b0; tpre = 1'b0; run = 1'b0; park = 1'b0; arun = 1'b0;
    kind = 3'h0; aset = 10'h000; wlo = 10'h000; whi = 10'h2cf; tang = 10'h064;
    tsrc = 2'h0; tint = 32'h0000_00c8; dflt = 32'h0000_0000; hl = 8'h08; ll = 8'h08;
    rnd = 32'h543b_0033;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    // steady signal: every kind on both edges, one extreme phase ratio among them
    for (int k = 0; k < 6; k++) begin
      for (int e = 0; e < 2; e++) begin
        rnd = lfsr(rnd);
        @(posedge clock_i);
        kind <= 3'(k);
        edge_f <= e[0];
        run <= 1'b1;
        hl <= (k == 2 && e == 0) ? 8'h01 : 8'h08 + 8'(rnd[4:0]);
        ll <= (k == 2 && e == 0) ? 8'h3f : 8'h08 + 8'(rnd[9:5]);
        repeat (300) @(posedge clock_i);
        get(1'b0, r, t);
        chk_word(r, expv(k, hl, ll));
        chk_word({31'h0, t}, 32'h0);
      end
    end
    // angle window: nothing outside it, full range acts like asynchronous
    @(posedge clock_i);
    tint <= 32'h0000_4e20;
    kind <= 3'h4;
    amode <= 1'b1;
    aset <= 10'h1f4;
    wlo <= 10'h000;
    whi <= 10'h00a;
    // a value already pending or in the divider may still come out; let it drain first
    repeat (30) @(posedge clock_i);
    n = 0;
    repeat (400) begin
      @(posedge clock_i);
      #1;
      if (valid === 1'b1 && tmo === 1'b0) n++;
    end
    chk_word(n, 0);
    @(posedge clock_i);
    whi <= 10'h2cf;
    repeat (300) @(posedge clock_i);
    get(1'b0, r, t);
    chk_word(r, expv(4, hl, ll));
    @(posedge clock_i);
    wlo <= 10'h258;
    whi <= 10'h00a;
    aset <= 10'h005;
    repeat (300) @(posedge clock_i);
    get(1'b0, r, t);
    chk_word(r, expv(4, hl, ll));
    // input dependent timeouts on a parked line, checks by interval, angle or both
    @(posedge clock_i);
    amode <= 1'b0;
    tint <= 32'h0000_003c;
    arun <= 1'b1;
    // the elapsed time must run from a rising edge, as the bench's own count does
    edge_f <= 1'b0;
    repeat (100) @(posedge clock_i);
    for (int k = 0; k < 6; k++) begin
      for (int lv = 0; lv < 2; lv++) begin
        if (k < 2 && lv == 0) continue;
        @(posedge clock_i);
        kind <= 3'(k);
        edge_f <= 1'b0;
        tsrc <= 2'((k + lv) % 3);
        park <= lv[0];
        run <= 1'b0;
        repeat (100) @(posedge clock_i);
        get(1'b1, r, t);
        if (k == 0) begin
          lo_w = fq(since - 32, 100);
          hi_w = fq(since + 2, 100);
          chk_range(r, lo_w, hi_w);
        end else if (k == 1) begin
          lo_w = fq(100000000, since + 2);
          hi_w = fq(100000000, since - 32);
          chk_range(r, lo_w, hi_w);
        end else begin
          chk_word(r, tmov(k, lv[0]));
        end
        chk_word({31'h0, t}, 32'h1);
        @(posedge clock_i);
        run <= 1'b1;
        repeat (200) @(posedge clock_i);
      end
    end
    // predefined procedures issue the configured default word
    tpre <= 1'b1;
    run <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      rnd = lfsr(rnd);
      @(posedge clock_i);
      tsrc <= 2'(s);
      dflt <= rnd;
      repeat (2) @(posedge clock_i);
      get(1'b1, r, t);
      chk_word(r, rnd);
    end
    test_done();
  end
endmodule // tb_top
